// File: hdl/sac_serial_ctrl.sv
// What this block does
// - sign-extend rx reads when enabled
// - frame error raises event when enabled
// - rx overflow raises event when enabled
// - tx underrun raises event when enabled
// - ignored overflow keeps buffered rx data
// - critical overflow halts serial operation
// - ignored underrun shifts zeros until refilled
// - critical underrun halts serial operation
// - audio enable selects audio protocol
// - mono sends each word on both channels
// - protocol field picks I2S, LJ, RJ, PCM
// - audio fields writable only while off
// - mono and protocol matter only in audio
// - unused bits read zero, fields reset zero
// - audio mode forces clock idle high
// - width select sets audio word sizes
`include "sac_consts.svh"

module sac_serial_ctrl (
   input  wire logic                clk_i,
   input  wire logic                rst_i,
   input  wire sac_pkg::sac_wb_req_t wb_req_i,
   output logic [31:0]              wb_dat_o,
   output logic                     wb_ack_o,
   input  wire logic                sck_i,
   input  wire logic                ws_i,
   input  wire logic                sdi_i,
   output logic                     sdo_o,
   output logic                     link_idle_high_o,
   output logic                     err_event_o
);

   // ===================================
   // helpers
   // data word length from the width select
   function automatic logic [5:0] sac_dlen(
      input sac_pkg::sac_cfg_t c);
      logic [5:0] n;
      n = `SAC_LEN16;
      if (!c.aud) begin
         // plain serial: 32, 16 or 8 bits
         n = c.w32 ? `SAC_LEN32
           : (c.w16 ? `SAC_LEN16 : `SAC_LEN8);
      end else if (c.w32) begin
         n = c.w16 ? `SAC_LEN24 : `SAC_LEN32;
      end
      return n;
   endfunction : sac_dlen

   // channel slot length: 32 or 16 in audio
   function automatic logic [5:0] sac_clen(
      input sac_pkg::sac_cfg_t c);
      logic [5:0] n;
      n = sac_dlen(c);
      if (c.aud) begin
         n = c.w32 ? `SAC_LEN32 : `SAC_LEN16;
      end
      return n;
   endfunction : sac_clen

   // copy the top data bit over the unused upper bits
   function automatic logic [31:0] sac_sext(
      input logic [31:0] d,
      input logic [5:0]  n);
      logic [31:0] r;
      logic [5:0]  top;
      r   = d;
      top = n - 6'h01;
      for (int i = 0; i < 32; i++) begin
         if (6'(i) >= n) begin
            r[i] = d[top[4:0]];
         end
      end
      return r;
   endfunction : sac_sext

   // ===================================
   // state
   sac_pkg::sac_bus_t  b;      // bus domain state
   sac_pkg::sac_bus_t  next_b; // its next value
   sac_pkg::sac_link_t l = '0; // power-on zero, else toggles stay x
   sac_pkg::sac_link_t next_l; // its next value

   // bus side working values
   logic        hit;     // new access this cycle
   logic [31:0] wm;      // byte lane mask
   logic [31:0] rv;      // read value
   logic [31:0] clr;     // status bits written one
   logic        ev_rx;   // word arrived from link
   logic        ev_ur;   // underrun seen on link
   logic        ev_fe;   // frame error on link
   logic        set_ov;  // overflow this cycle
   logic        set_ur;  // underrun this cycle
   logic        set_fe;  // frame error this cycle
   logic        hlt_set; // a critical error

   // link side working values
   sac_pkg::sac_cfg_t c; // synchronised config
   logic        run;      // link may operate
   logic [5:0]  dl;       // data length
   logic [5:0]  cl;       // channel length
   logic [5:0]  off;      // data start in slot
   logic        start;    // channel or word start
   logic        act;      // slot is live
   logic [5:0]  q;        // bit index this edge
   logic        ch;       // channel of this edge
   logic        load;     // fetch a new tx word
   logic        inwin;    // bit inside data window
   logic        mono;     // effective mono
   logic [31:0] word;     // word to transmit
   logic [31:0] al;       // word aligned to msb
   logic [5:0]  shamt;    // alignment shift

   // ===================================
   // bus domain next state
   always_comb begin
      next_b  = b;
      rv      = '0;
      clr     = '0;
      hit     = wb_req_i.cyc & wb_req_i.stb & ~b.ack;
      wm      = {{8{wb_req_i.sel[3]}},
                 {8{wb_req_i.sel[2]}},
                 {8{wb_req_i.sel[1]}},
                 {8{wb_req_i.sel[0]}}};
      // toggles from the link: two stages, plus history on the rx, ur and fe toggles
      next_b.rx_sy  = {b.rx_sy[1:0], l.rx_tog};
      next_b.ur_sy  = {b.ur_sy[1:0], l.ur_tog};
      next_b.fe_sy  = {b.fe_sy[1:0], l.fe_tog};
      next_b.ack_sy = {b.ack_sy[0], l.ack};
      ev_rx   = b.rx_sy[2] ^ b.rx_sy[1];
      ev_ur   = b.ur_sy[2] ^ b.ur_sy[1];
      ev_fe   = b.fe_sy[2] ^ b.fe_sy[1];
      set_ov  = ev_rx & b.run & b.rx_full;
      set_ur  = ev_ur & b.run;
      set_fe  = ev_fe & b.run;
      hlt_set = (set_ov & ~b.ign_ov)
              | (set_ur & ~b.ign_ur);
      // a full buffer keeps its word on overflow
      if (ev_rx && b.run && !b.rx_full) begin
         next_b.rxd     = l.rx_hold;
         next_b.rx_full = 1'b1;
      end
      // tx handshake: offer the word, wait for echo
      if (b.tx_full && !b.tx_pend) begin
         next_b.tx_req  = ~b.tx_req;
         next_b.tx_pend = 1'b1;
      end else if (b.tx_pend
                   && (b.ack_sy[1] == b.tx_req)) begin
         next_b.tx_pend = 1'b0;
         next_b.tx_full = 1'b0;
      end
      // answer every access one cycle later
      next_b.ack = hit;
      next_b.dat = '0;
      // register reads; unmapped reads give zero
      unique case (wb_req_i.adr)
         `SAC_OFS_CTL1: begin
            rv[`SAC_C1_ON]  = b.on;
            rv[`SAC_C1_W32] = b.cfg.w32;
            rv[`SAC_C1_W16] = b.cfg.w16;
            rv[`SAC_C1_POL] = b.pol;
         end
         `SAC_OFS_CTL2: begin
            // unused bits stay zero
            rv[`SAC_C2_SGN]  = b.sgn;
            rv[`SAC_C2_FEEN] = b.fe_en;
            rv[`SAC_C2_OVEN] = b.ov_en;
            rv[`SAC_C2_UREN] = b.ur_en;
            rv[`SAC_C2_IGOV] = b.ign_ov;
            rv[`SAC_C2_IGUR] = b.ign_ur;
            rv[`SAC_C2_AUD]  = b.cfg.aud;
            rv[`SAC_C2_MONO] = b.cfg.mono;
            rv[`SAC_C2_PMSB:`SAC_C2_PLSB] = b.cfg.proto;
         end
         `SAC_OFS_STAT: begin
            rv[`SAC_ST_RXF]  = b.rx_full;
            rv[`SAC_ST_TXF]  = b.tx_full;
            rv[`SAC_ST_HALT] = b.halt;
            rv[`SAC_ST_OV]   = b.ov_f;
            rv[`SAC_ST_UR]   = b.ur_f;
            rv[`SAC_ST_FE]   = b.fe_f;
         end
         `SAC_OFS_RXB: begin
            rv = b.sgn ? sac_sext(b.rxd, sac_dlen(b.cfg))
                       : b.rxd;
         end
         default: begin
            rv = '0;
         end
      endcase
      if (hit && !wb_req_i.we) begin
         next_b.dat = rv;
         // reading the rx word frees the buffer
         if (wb_req_i.adr == `SAC_OFS_RXB && b.rx_full) begin
            next_b.rx_full = 1'b0;
         end
      end
      // register writes through the byte lanes
      if (hit && wb_req_i.we) begin
         rv = (rv & ~wm) | (wb_req_i.dat & wm);
         unique case (wb_req_i.adr)
            `SAC_OFS_CTL1: begin
               next_b.on = rv[`SAC_C1_ON];
               // word shape changes only while off
               if (!b.on) begin
                  next_b.cfg.w32 = rv[`SAC_C1_W32];
                  next_b.cfg.w16 = rv[`SAC_C1_W16];
                  next_b.pol     = rv[`SAC_C1_POL];
               end
            end
            `SAC_OFS_CTL2: begin
               next_b.sgn    = rv[`SAC_C2_SGN];
               next_b.fe_en  = rv[`SAC_C2_FEEN];
               next_b.ov_en  = rv[`SAC_C2_OVEN];
               next_b.ur_en  = rv[`SAC_C2_UREN];
               next_b.ign_ov = rv[`SAC_C2_IGOV];
               next_b.ign_ur = rv[`SAC_C2_IGUR];
               if (!b.on) begin
                  next_b.cfg.aud   = rv[`SAC_C2_AUD];
                  next_b.cfg.mono  = rv[`SAC_C2_MONO];
                  next_b.cfg.proto = sac_pkg::sac_proto_t'(
                     rv[`SAC_C2_PMSB:`SAC_C2_PLSB]);
               end
            end
            `SAC_OFS_STAT: begin
               clr = wb_req_i.dat & wm;
            end
            `SAC_OFS_TXB: begin
               // a write to a full buffer is dropped
               if (!b.tx_full) begin
                  next_b.txd     = rv;
                  next_b.tx_full = 1'b1;
               end
            end
            default: begin
               clr = '0;
            end
         endcase
      end
      // sticky flags: a new event beats the clear
      next_b.ov_f = (b.ov_f & ~clr[`SAC_ST_OV]) | set_ov;
      next_b.ur_f = (b.ur_f & ~clr[`SAC_ST_UR]) | set_ur;
      next_b.fe_f = (b.fe_f & ~clr[`SAC_ST_FE]) | set_fe;
      // halt lasts until software turns the module off
      next_b.halt = (b.halt | hlt_set) & next_b.on;
      next_b.run  = next_b.on & ~next_b.halt;
      // one held request from all enabled errors
      next_b.err  = (next_b.fe_f & next_b.fe_en)
                  | (next_b.ov_f & next_b.ov_en)
                  | (next_b.ur_f & next_b.ur_en);
      next_b.idle = next_b.cfg.aud | next_b.pol;
   end

   // ===================================
   // bus domain registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         b <= {$bits(sac_pkg::sac_bus_t){`SAC_RST_FIELD}};
      end else begin
         b <= next_b;
      end
   end

   // ===================================
   // link domain next state
   always_comb begin
      next_l        = l;
      // level crossings into the link domain
      next_l.run_sy = {l.run_sy[0], b.run};
      next_l.cfg1   = b.cfg;
      next_l.cfg2   = l.cfg1;
      next_l.req_sy = {l.req_sy[0], b.tx_req};
      next_l.ws_d   = ws_i;
      next_l.ws_dd  = l.ws_d;
      c     = l.cfg2;
      run   = l.run_sy[1];
      dl    = sac_dlen(c);
      cl    = sac_clen(c);
      mono  = c.aud & c.mono;
      shamt = `SAC_LEN32 - dl;
      off   = '0;
      word  = '0;
      // right-justified data ends at the slot end
      if (c.aud && c.proto == sac_pkg::SAC_RJ) begin
         off = cl - dl;
      end
      // find the start of a slot
      if (!c.aud) begin
         start = ~ws_i & l.ws_d;
         ch    = 1'b0;
      end else begin
         unique case (c.proto)
            sac_pkg::SAC_PCM: start = ws_i & ~l.ws_d;
            sac_pkg::SAC_I2S: start = l.ws_d ^ l.ws_dd;
            sac_pkg::SAC_LJ,
            sac_pkg::SAC_RJ:  start = ws_i ^ l.ws_d;
         endcase
         // i2s is one bit late, left on select low; lj and rj take left on select high
         ch = (c.proto == sac_pkg::SAC_PCM) ? 1'b0
            : (c.proto == sac_pkg::SAC_I2S) ? l.ws_d
            : ~ws_i;
         ch = start ? ch : l.chan;
      end
      q     = start ? '0 : l.pos;
      act   = c.aud ? (start | l.lock) : ~ws_i;
      load  = run & act & (q == off);
      inwin = run & act & (q >= off) & (q < off + dl);
      next_l.sdo = 1'b0;
      if (!run) begin
         // stopped: drop framing, drive low
         next_l.pos  = '0;
         next_l.chan = 1'b0;
         next_l.lock = 1'b0;
      end else begin
         // a slot of the wrong length is a frame error
         if (c.aud && start && l.lock
             && (l.pos != cl || (c.proto
                 == sac_pkg::SAC_PCM && !l.chan))) begin
            next_l.fe_tog = ~l.fe_tog;
         end
         // select released inside a word
         if (!c.aud && ws_i && !l.ws_d && l.pos != '0) begin
            next_l.fe_tog = ~l.fe_tog;
         end
         next_l.chan = ch;
         next_l.lock = c.aud & (l.lock | start);
         if (!act) begin
            next_l.pos = '0;
         end else if (!c.aud) begin
            // plain serial words follow back to back
            next_l.pos = (q == dl - 6'h01) ? '0 : q + 6'h01;
         end else if (c.proto == sac_pkg::SAC_PCM
                      && !ch && q == cl - 6'h01) begin
            // pcm: right slot follows left directly
            next_l.pos  = '0;
            next_l.chan = 1'b1;
         end else begin
            next_l.pos = (q == `SAC_POS_MAX) ? q : q + 6'h01;
         end
      end
      // pick the word for this slot
      if (load) begin
         if (mono && ch) begin
            word = l.last;
         end else if (l.nxt_vld) begin
            word           = l.nxt;
            next_l.last    = l.nxt;
            next_l.nxt_vld = 1'b0;
         end else begin
            // empty: send zeros and report it
            word          = '0;
            next_l.ur_tog = ~l.ur_tog;
         end
         al           = word << shamt;
         next_l.sdo   = al[31];
         next_l.sh_tx = al << 1;
         next_l.sh_rx = {31'h0, sdi_i};
      end else if (inwin) begin
         al           = '0;
         next_l.sdo   = l.sh_tx[31];
         next_l.sh_tx = l.sh_tx << 1;
         next_l.sh_rx = {l.sh_rx[30:0], sdi_i};
      end else begin
         al = '0;
      end
      // last data bit: hand the word to the bus side
      if (inwin && q == off + dl - 6'h01) begin
         next_l.rx_hold = next_l.sh_rx;
         next_l.rx_tog  = ~l.rx_tog;
      end
      // take an offered tx word into the holding slot
      if (l.req_sy[1] != l.ack && !next_l.nxt_vld) begin
         next_l.nxt     = b.txd;
         next_l.nxt_vld = 1'b1;
         next_l.ack     = ~l.ack;
      end
   end

   // ===================================
   // link domain registers
   // the link clock may stop, so nothing here resets;
   // a stopped run level clears framing instead
   always_ff @(posedge sck_i) begin
      l <= next_l;
   end

   // ===================================
   // outputs, each straight from a flip-flop
   assign wb_dat_o         = b.dat;
   assign wb_ack_o         = b.ack;
   assign err_event_o      = b.err;
   assign link_idle_high_o = b.idle;
   assign sdo_o            = l.sdo;

endmodule : sac_serial_ctrl

// File: inc/sac_consts.svh
`ifndef SAC_CONSTS_SVH
`define SAC_CONSTS_SVH
// ===================================
// register byte offsets
`define SAC_OFS_CTL1 8'h00
`define SAC_OFS_CTL2 8'h04
`define SAC_OFS_STAT 8'h08
`define SAC_OFS_TXB  8'h0C
`define SAC_OFS_RXB  8'h10
// ===================================
// control one fields
`define SAC_C1_ON   15
`define SAC_C1_W32  11
`define SAC_C1_W16  10
`define SAC_C1_POL  6
// ===================================
// serial control two fields
`define SAC_C2_SGN  15
`define SAC_C2_FEEN 12
`define SAC_C2_OVEN 11
`define SAC_C2_UREN 10
`define SAC_C2_IGOV 9
`define SAC_C2_IGUR 8
`define SAC_C2_AUD  7
`define SAC_C2_MONO 3
`define SAC_C2_PMSB 1
`define SAC_C2_PLSB 0
// ===================================
// status fields
`define SAC_ST_RXF  0
`define SAC_ST_TXF  1
`define SAC_ST_HALT 2
`define SAC_ST_OV   6
`define SAC_ST_UR   8
`define SAC_ST_FE   12
// ===================================
// reset value of every field, word lengths
`define SAC_RST_FIELD 1'b0
`define SAC_LEN8  6'h08
`define SAC_LEN16 6'h10
`define SAC_LEN24 6'h18
`define SAC_LEN32 6'h20
`define SAC_POS_MAX 6'h3F
`endif

// File: inc/sac_pkg.sv
package sac_pkg;
   // ===================================
   // audio protocol variants, in field order
   typedef enum logic [1:0] {
      SAC_I2S, SAC_LJ, SAC_RJ, SAC_PCM
   } sac_proto_t;

   // wishbone request from the master
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } sac_wb_req_t;

   // link configuration, quasi-static while on
   typedef struct packed {
      logic       aud;
      logic       mono;
      sac_proto_t proto;
      logic       w32;
      logic       w16;
   } sac_cfg_t;

   // all state of the bus clock domain
   typedef struct packed {
      logic        on;
      logic        pol;
      sac_cfg_t    cfg;
      logic        sgn;
      logic        fe_en;
      logic        ov_en;
      logic        ur_en;
      logic        ign_ov;
      logic        ign_ur;
      logic        fe_f;
      logic        ov_f;
      logic        ur_f;
      logic        halt;
      logic        run;
      logic [31:0] txd;
      logic        tx_full;
      logic        tx_pend;
      logic        tx_req;
      logic [1:0]  ack_sy;
      logic [31:0] rxd;
      logic        rx_full;
      logic [2:0]  rx_sy;
      logic [2:0]  ur_sy;
      logic [2:0]  fe_sy;
      logic        ack;
      logic [31:0] dat;
      logic        err;
      logic        idle;
   } sac_bus_t;

   // all state of the link clock domain
   typedef struct packed {
      logic [1:0]  run_sy;
      sac_cfg_t    cfg1;
      sac_cfg_t    cfg2;
      logic [1:0]  req_sy;
      logic        ack;
      logic [31:0] nxt;
      logic        nxt_vld;
      logic [31:0] last;
      logic [31:0] sh_tx;
      logic [31:0] sh_rx;
      logic [31:0] rx_hold;
      logic        rx_tog;
      logic        ur_tog;
      logic        fe_tog;
      logic        ws_d;
      logic        ws_dd;
      logic        lock;
      logic        chan;
      logic [5:0]  pos;
      logic        sdo;
   } sac_link_t;
endpackage : sac_pkg

// File: testbench/sac_link_model.sv
// =====
// far-side serial device; clock runs only during bursts
module sac_link_model (
   input  wire logic idle_i,  // idle level the block asks for
   input  wire logic sdo_i,   // serial data from the block
   output logic      sck_o,   // link clock, 15 ns period
   output logic      ws_o,    // select or word select
   output logic      sdi_o    // serial data to the block
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      sck_o = 1'b0;
      ws_o  = 1'b1;
      sdi_o = 1'b0;
   end
   // n clocks, pattern bit n-1 first; sdo read late in the high phase
   task automatic burst(input int n, input logic [79:0] ws_p,
                        input logic [79:0] sd_p, output logic [79:0] got);
      got = '0;
      for (int i = n - 1; i >= 0; i--) begin
         sck_o = 1'b0;
         ws_o  = ws_p[i];
         sdi_o = sd_p[i];
         #7.5;
         sck_o = 1'b1;
         #7.5;
         got[i] = sdo_i;
      end
      sck_o = idle_i;  // clock rests at the requested level
      sdi_o = ~sdi_o;  // released line must not look like held data
   endtask : burst
endmodule : sac_link_model

// File: testbench/sac_serial_ctrl_chk.sv
// =====
// bus-side checks, seeing only the top module's ports
module sac_serial_ctrl_chk (
   input wire logic                 clk_i,
   input wire logic                 rst_i,
   input wire sac_pkg::sac_wb_req_t wb_req_i,
   input wire logic [31:0]          wb_dat_o,
   input wire logic                 wb_ack_o,
   input wire logic                 sck_i,
   input wire logic                 ws_i,
   input wire logic                 sdi_i,
   input wire logic                 sdo_o,
   input wire logic                 link_idle_high_o,
   input wire logic                 err_event_o
);
   timeunit 1ns;
   timeprecision 100ps;
   sac_pkg::sac_wb_req_t cap;  // request as taken, used in its ack cycle
   logic       on_q;           // module on, as last written
   logic [5:0] hi_q;           // control two bits 15 and 12..8
   logic [3:0] lo_q;           // audio enable, mono, protocol
   logic       rd;             // ack cycle of a read
   assign rd = wb_ack_o & ~cap.we;
   // shadows follow writes at their ack; audio fields lock while on
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cap  <= '0;
         on_q <= 1'b0;
         hi_q <= '0;
         lo_q <= '0;
      end else if (wb_req_i.cyc && wb_req_i.stb && !wb_ack_o) begin
         cap <= wb_req_i;
      end else if (wb_ack_o && cap.we) begin
         if (cap.adr == 8'h00 && cap.sel[1]) begin
            on_q <= cap.dat[15];
         end
         if (cap.adr == 8'h04 && cap.sel[1]) begin
            hi_q <= {cap.dat[15], cap.dat[12:8]};
         end
         if (cap.adr == 8'h04 && cap.sel[0] && !on_q) begin
            lo_q <= {cap.dat[7], cap.dat[3], cap.dat[1:0]};
         end
      end
   end
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   chk_ack_next: assert property ( // answer
      wb_req_i.cyc && wb_req_i.stb && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered one cycle later");
   chk_ack_pulse: assert property ( // pulse
      wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   chk_dat_idle: assert property ( // quiet data
      !wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   chk_ctl2_unused: assert property ( // zero bits
      rd && cap.adr == 8'h04 |-> (wb_dat_o & ~32'h00009F8B) == 32'h0)
      else $error("unused control two bit reads one");
   chk_ctl2_lock: assert property ( // locked fields
      rd && cap.adr == 8'h04 |-> {wb_dat_o[15], wb_dat_o[12:8],
      wb_dat_o[7], wb_dat_o[3], wb_dat_o[1:0]} == {hi_q, lo_q})
      else $error("control two readback wrong");
   chk_unmapped_zero: assert property ( // empty map
      rd && !(cap.adr inside {8'h00, 8'h04, 8'h08, 8'h10})
      |-> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   chk_audio_idle: assert property ( // idle level
      rd && cap.adr == 8'h04 && wb_dat_o[7] |-> link_idle_high_o)
      else $error("audio mode without high idle");
   chk_err_cause: assert property ( // merged event
      $rose(err_event_o) |=> hi_q[4:2] != 3'b000)
      else $error("error event with no enable set");
   chk_err_masked: assert property ( // masked
      hi_q[4:2] == 3'b000 ##1 hi_q[4:2] == 3'b000
      |-> !$past(err_event_o))
      else $error("error event while all disabled");
endmodule : sac_serial_ctrl_chk

bind sac_serial_ctrl sac_serial_ctrl_chk i_sac_serial_ctrl_chk (
   .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sck_i(sck_i), .ws_i(ws_i),
   .sdi_i(sdi_i), .sdo_o(sdo_o), .link_idle_high_o(link_idle_high_o),
   .err_event_o(err_event_o));

// File: testbench/sac_serial_ctrl_tb.sv
`include "sac_consts.svh"
// =====
// bench top: bus master, link partner, one task per scenario
module sac_serial_ctrl_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic                 clk_i = 1'b0;  // 50 MHz bus clock
   logic                 rst_i = 1'b1;  // synchronous reset
   sac_pkg::sac_wb_req_t req   = '0;    // bus request
   logic [31:0]          dat;           // read data
   logic                 ack;           // bus answer
   logic                 sck, ws, sdi, sdo, idle, err;
   logic [79:0]          g;             // bits seen by the partner
   int                   err_count   = 0;
   int                   comparisons = 0;
   always #10 clk_i = ~clk_i;
   sac_serial_ctrl i_sac_serial_ctrl (
      .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_dat_o(dat),
      .wb_ack_o(ack), .sck_i(sck), .ws_i(ws), .sdi_i(sdi), .sdo_o(sdo),
      .link_idle_high_o(idle), .err_event_o(err));
   sac_link_model i_sac_link_model (
      .idle_i(idle), .sdo_i(sdo), .sck_o(sck), .ws_o(ws), .sdi_o(sdi));
   // =====
   // shared tasks
   task automatic summarize();
      $display("comparisons %0d, mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : summarize
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk
   // request holds until ack is seen at an edge, then is released
   task automatic wb(input logic we, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = dat;
      req <= '0;
      if (ack !== 1'b1) begin
         err_count++;
         $display("MISMATCH at %0t: bus cycle not answered", $time);
         summarize();
      end
   endtask : wb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask : wr
   task automatic rc(input logic [7:0] a, input logic [31:0] e,
                     input logic [31:0] m = 32'hFFFFFFFF);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, q);
      chk(q & m, e);
   endtask : rc
   // a burst on the link, then time for the crossing back
   task automatic fr(input int n, input logic [79:0] w, input logic [79:0] s);
      i_sac_link_model.burst(n, w, s, g);
      repeat (12) @(posedge clk_i);
   endtask : fr
   // =====
   // scenarios
   task automatic t_regs();
      rc(`SAC_OFS_CTL2, 32'h0);                  // reset value
      chk({30'h0, idle, err}, 32'h0);            // reset outputs
      wr(`SAC_OFS_CTL2, 32'hFFFFFFFF);
      rc(`SAC_OFS_CTL2, 32'h00009F8B);           // used bits
      chk({31'h0, idle}, 32'h1);                 // forced idle
      for (int p = 0; p < 4; p++) begin
         wr(`SAC_OFS_CTL2, 32'h80 | 32'(p));
         rc(`SAC_OFS_CTL2, 32'h80 | 32'(p));     // each code
      end
      wr(8'h14, 32'hFFFFFFFF);
      rc(8'h14, 32'h0);                          // unmapped
      wr(`SAC_OFS_CTL2, 32'h0);
      $display("t_regs finished");
   endtask : t_regs
   task automatic t_lock();
      wr(`SAC_OFS_CTL1, 32'h8000);
      wr(`SAC_OFS_CTL2, 32'hFFFFFFFF);
      rc(`SAC_OFS_CTL2, 32'h00009F00);           // locked while on
      chk({31'h0, idle}, 32'h0);                 // idle low
      wr(`SAC_OFS_CTL1, 32'h0);
      wr(`SAC_OFS_CTL2, 32'h0);
      $display("t_lock finished");
   endtask : t_lock
   task automatic t_plain();
      for (int s = 0; s < 2; s++) begin
         wr(`SAC_OFS_CTL2, s ? 32'h8008 : 32'h0008);
         wr(`SAC_OFS_CTL1, 32'h8000);
         wr(`SAC_OFS_TXB, 32'hA5);
         fr(20, 80'hFFF00, 80'h85);
         chk({24'h0, g[7:0]}, 32'hA5);           // plain
         rc(`SAC_OFS_RXB, s ? 32'hFFFFFF85 : 32'h85); // fill
         wr(`SAC_OFS_CTL1, 32'h0);
      end
      $display("t_plain finished");
   endtask : t_plain
   task automatic t_ovf();
      for (int s = 0; s < 2; s++) begin
         wr(`SAC_OFS_STAT, 32'hFFFFFFFF);
         wr(`SAC_OFS_CTL2, s ? 32'h0100 : 32'h0B00);
         wr(`SAC_OFS_CTL1, 32'h8000);
         fr(28, 80'hFFF0000, 80'h1122);
         chk({31'h0, err}, s ? 32'h0 : 32'h1);   // event gate
         rc(`SAC_OFS_STAT, s ? 32'h145 : 32'h141); // halt
         rc(`SAC_OFS_RXB, 32'h11);                 // old kept
         wr(`SAC_OFS_STAT, 32'h40);
         repeat (4) @(posedge clk_i);
         chk({31'h0, err}, 32'h0);               // event drops
         wr(`SAC_OFS_CTL1, 32'h0);
      end
      $display("t_ovf finished");
   endtask : t_ovf
   task automatic t_udr();
      for (int s = 0; s < 2; s++) begin
         wr(`SAC_OFS_STAT, 32'hFFFFFFFF);
         wr(`SAC_OFS_CTL2, s ? 32'h0000 : 32'h0500);
         wr(`SAC_OFS_CTL1, 32'h8000);
         fr(20, 80'hFFF00, 80'h5A);
         chk({24'h0, g[7:0]}, 32'h0);            // zero fill
         chk({31'h0, err}, s ? 32'h0 : 32'h1);   // event gate
         rc(`SAC_OFS_STAT, s ? 32'h104 : 32'h100, 32'h104);
         if (s == 0) begin
            rc(`SAC_OFS_RXB, 32'h5A);            // still runs
         end
         wr(`SAC_OFS_CTL1, 32'h0);
      end
      $display("t_udr finished");
   endtask : t_udr
   task automatic t_frm();
      for (int s = 0; s < 2; s++) begin
         wr(`SAC_OFS_STAT, 32'hFFFFFFFF);
         wr(`SAC_OFS_CTL2, s ? 32'h0100 : 32'h1100);
         wr(`SAC_OFS_CTL1, 32'h8000);
         wr(`SAC_OFS_TXB, 32'h0);
         fr(18, 80'h3FFC3, 80'h0);
         chk({31'h0, err}, s ? 32'h0 : 32'h1);   // event gate
         rc(`SAC_OFS_STAT, 32'h1000, 32'h1004);  // flag only
         wr(`SAC_OFS_CTL1, 32'h0);
      end
      $display("t_frm finished");
   endtask : t_frm
   task automatic t_mono();
      wr(`SAC_OFS_STAT, 32'hFFFFFFFF);
      wr(`SAC_OFS_CTL2, 32'h0389);
      wr(`SAC_OFS_CTL1, 32'h8000);
      wr(`SAC_OFS_TXB, 32'hC3A5);
      fr(44, 80'hFFFF0000, 80'h0);
      chk(g[31:0], 32'hC3A5C3A5);   // both slots
      wr(`SAC_OFS_CTL1, 32'h0);
      $display("t_mono finished");
   endtask : t_mono
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_lock();
      t_plain();
      t_ovf();
      t_udr();
      t_frm();
      t_mono();
      summarize();
   end
endmodule : sac_serial_ctrl_tb
